//--- tsrc_map.svh
// register addresses, field positions and reset values of the split reload capture timer
`ifndef TSRC_MAP_SVH
`define TSRC_MAP_SVH

// ==========================================================
// register addresses
`define TSRC_ADDR_CTRL 8'h91
`define TSRC_ADDR_RELOAD_LOW 8'h92
`define TSRC_ADDR_RELOAD_HIGH 8'h93
`define TSRC_ADDR_COUNT_LOW 8'h94
`define TSRC_ADDR_COUNT_HIGH 8'h95

// ==========================================================
// control register bit positions
`define TSRC_BIT_HIGH_FLAG 7
`define TSRC_BIT_LOW_FLAG 6
`define TSRC_BIT_LOW_IRQ_EN 5
`define TSRC_BIT_CAPTURE_EN 4
`define TSRC_BIT_SPLIT 3
`define TSRC_BIT_RUN 2
`define TSRC_BIT_UNUSED 1
`define TSRC_BIT_EXT_CLK 0

// ==========================================================
// reset values and constants
`define TSRC_RST_CTRL 8'h00
`define TSRC_RST_BYTE 8'h00
`define TSRC_BYTE_MAX 8'hff
`define TSRC_RD_UNMAPPED 8'h00

`endif

//--- tsrc_pkg.sv
// types shared by the split reload capture timer
package tsrc_pkg;

  // control register layout, msb first
  typedef struct packed {
    logic high_overflow_flag;
    logic low_overflow_flag;
    logic low_byte_irq_enable;
    logic comparator_capture_enable;
    logic split_mode_select;
    logic run_control;
    logic unused;
    logic external_clock_select;
  } tsrc_ctrl_t;

  // one special function register access
  typedef struct packed {
    logic [7:0] addr;
    logic wr_en;
    logic rd_en;
    logic [7:0] wr_data;
  } tsrc_sfr_req_t;

endpackage

//--- tsrc_byte_counter.sv
// one 8-bit count byte with wrap detect, reload on wrap and software write
`timescale 1ns/100ps
module tsrc_byte_counter
  import tsrc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic count_en,
  input wire logic reload_on_wrap,
  input wire logic [7:0] reload_val,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] count_q,
  output logic wrap
);
`include "tsrc_map.svh"

  logic [7:0] count_d;

  assign wrap = count_en && (count_q == `TSRC_BYTE_MAX);

  always_comb begin
    count_d = count_q;
    if (wr_en) begin
      count_d = wr_data;
    end else if (wrap) begin
      count_d = reload_on_wrap ? reload_val : `TSRC_RST_BYTE;
    end else if (count_en) begin
      count_d = count_q + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= `TSRC_RST_BYTE;
    end else begin
      count_q <= count_d;
    end
  end

endmodule

//--- tsrc_timer.sv
// split reload capture timer: control bits, reload bytes, count bytes, capture
`timescale 1ns/100ps
// How it works
// R01: with the low-byte interrupt enable and the timer interrupt enable both set, each low byte overflow requests an interrupt.
// R02: a 1 in the comparator capture enable puts the timer in capture mode, a 0 leaves it off.
// R03: in capture mode each rising edge of the comparator output copies the 16-bit count into the reload bytes.
// R04: with the timer interrupt enabled each capture event also requests an interrupt.
// R05: split select 0 runs one 16-bit auto-reload counter, 1 runs two independent 8-bit auto-reload counters.
// R06: the low reload byte holds the low eight reload bits and is read and written at address 0x92.
// R07: the high overflow flag is set when the high count byte wraps from 0xff, the full count from 0xffff in 16-bit mode.
// R08: software clears the high overflow flag itself; hardware never clears it.
// R09: the high reload byte holds the upper eight reload bits and with the low byte forms the reload and capture value.
// R10: run control enables counting; in split mode it gates only the high byte while the low byte always runs.
module tsrc_timer
  import tsrc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire tsrc_sfr_req_t sfr_req,
  output logic [7:0] sfr_rd_data_q,
  input wire logic count_tick,
  input wire logic comparator_zero_output,
  input wire logic timer_irq_enable,
  input wire logic capture_irq_ack,
  output logic timer_irq_req,
  output logic external_clock_select,
  output logic high_overflow_flag,
  output logic low_overflow_flag
);
`include "tsrc_map.svh"

  // ==========================================================
  // address decode
  function automatic logic sfr_hit(input logic [7:0] addr, input logic [7:0] target);
    sfr_hit = (addr == target);
  endfunction

  logic wr_ctrl;
  logic wr_rl_low;
  logic wr_rl_high;
  logic wr_cnt_low;
  logic wr_cnt_high;

  assign wr_ctrl = sfr_req.wr_en && sfr_hit(sfr_req.addr, `TSRC_ADDR_CTRL);
  assign wr_rl_low = sfr_req.wr_en && sfr_hit(sfr_req.addr, `TSRC_ADDR_RELOAD_LOW);
  assign wr_rl_high = sfr_req.wr_en && sfr_hit(sfr_req.addr, `TSRC_ADDR_RELOAD_HIGH);
  assign wr_cnt_low = sfr_req.wr_en && sfr_hit(sfr_req.addr, `TSRC_ADDR_COUNT_LOW);
  assign wr_cnt_high = sfr_req.wr_en && sfr_hit(sfr_req.addr, `TSRC_ADDR_COUNT_HIGH);

  // ==========================================================
  // counting
  tsrc_ctrl_t ctrl_q;
  tsrc_ctrl_t ctrl_d;
  logic [7:0] reload_low_q;
  logic [7:0] reload_low_d;
  logic [7:0] reload_high_q;
  logic [7:0] reload_high_d;
  logic [7:0] count_low;
  logic [7:0] count_high;
  logic low_en;
  logic high_en;
  logic low_wrap;
  logic high_wrap;
  logic low_reload;

  always_comb begin
    if (ctrl_q.split_mode_select) begin
      low_en = count_tick; // R10
      high_en = count_tick && ctrl_q.run_control; // R10
      low_reload = 1'b1; // R05
    end else begin
      // 16-bit: the low byte reloads only on the full wrap
      low_en = count_tick && ctrl_q.run_control; // R10
      high_en = low_wrap; // R05
      low_reload = (count_high == `TSRC_BYTE_MAX); // R05
    end
  end

  // a count byte write wins over counting in the same cycle
  tsrc_byte_counter u_count_low (
    .clk(clk),
    .rst(rst),
    .count_en(low_en),
    .reload_on_wrap(low_reload),
    .reload_val(reload_low_q),
    .wr_en(wr_cnt_low),
    .wr_data(sfr_req.wr_data),
    .count_q(count_low),
    .wrap(low_wrap)
  );

  tsrc_byte_counter u_count_high (
    .clk(clk),
    .rst(rst),
    .count_en(high_en),
    .reload_on_wrap(1'b1),
    .reload_val(reload_high_q),
    .wr_en(wr_cnt_high),
    .wr_data(sfr_req.wr_data),
    .count_q(count_high),
    .wrap(high_wrap)
  );

  // ==========================================================
  // comparator capture
  logic cmp_q;
  logic cmp_d;
  logic capture;
  logic capture_pend_q;
  logic capture_pend_d;

  assign capture = ctrl_q.comparator_capture_enable && comparator_zero_output && !cmp_q; // R02

  // ack and a new capture in one cycle: the capture stays pending
  always_comb begin
    cmp_d = comparator_zero_output;
    capture_pend_d = capture_pend_q;
    if (capture_irq_ack) begin
      capture_pend_d = 1'b0;
    end
    if (capture) begin
      capture_pend_d = 1'b1; // R04
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cmp_q <= 1'b0;
      capture_pend_q <= 1'b0;
    end else begin
      cmp_q <= cmp_d;
      capture_pend_q <= capture_pend_d;
    end
  end

  // ==========================================================
  // control and reload registers
  always_comb begin
    ctrl_d = ctrl_q;
    reload_low_d = reload_low_q;
    reload_high_d = reload_high_q;
    // bit 1 is not stored and reads as zero
    if (wr_ctrl) begin
      ctrl_d = tsrc_ctrl_t'(sfr_req.wr_data); // R02
      ctrl_d.unused = 1'b0;
    end
    // hardware set wins over a software clear in the same cycle
    if (low_wrap) begin
      ctrl_d.low_overflow_flag = 1'b1;
    end
    if (high_wrap) begin
      ctrl_d.high_overflow_flag = 1'b1; // R07 R08
    end
    if (wr_rl_low) begin
      reload_low_d = sfr_req.wr_data; // R06
    end
    if (wr_rl_high) begin
      reload_high_d = sfr_req.wr_data; // R09
    end
    // capture wins over a software write of the reload bytes
    if (capture) begin
      reload_low_d = count_low; // R03
      reload_high_d = count_high; // R03 R09
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= tsrc_ctrl_t'(`TSRC_RST_CTRL);
      reload_low_q <= `TSRC_RST_BYTE;
      reload_high_q <= `TSRC_RST_BYTE;
    end else begin
      ctrl_q <= ctrl_d;
      reload_low_q <= reload_low_d;
      reload_high_q <= reload_high_d;
    end
  end

  // ==========================================================
  // interrupt request
  logic irq_high;
  logic irq_low;
  logic irq_capture;

  always_comb begin
    irq_high = ctrl_q.high_overflow_flag; // R07
    irq_low = ctrl_q.low_byte_irq_enable && ctrl_q.low_overflow_flag; // R01
    irq_capture = capture_pend_q; // R04
    timer_irq_req = timer_irq_enable && (irq_high || irq_low || irq_capture);
  end

  assign external_clock_select = ctrl_q.external_clock_select;
  assign high_overflow_flag = ctrl_q.high_overflow_flag;
  assign low_overflow_flag = ctrl_q.low_overflow_flag;

  // ==========================================================
  // read port
  logic [7:0] rd_data_d;

  // reads have no side effects on counters or flags
  always_comb begin
    rd_data_d = sfr_rd_data_q;
    if (sfr_req.rd_en) begin
      unique case (sfr_req.addr)
        `TSRC_ADDR_CTRL: rd_data_d = ctrl_q;
        `TSRC_ADDR_RELOAD_LOW: rd_data_d = reload_low_q; // R06
        `TSRC_ADDR_RELOAD_HIGH: rd_data_d = reload_high_q;
        `TSRC_ADDR_COUNT_LOW: rd_data_d = count_low;
        `TSRC_ADDR_COUNT_HIGH: rd_data_d = count_high;
        default: rd_data_d = `TSRC_RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sfr_rd_data_q <= `TSRC_RST_BYTE;
    end else begin
      sfr_rd_data_q <= rd_data_d;
    end
  end

endmodule

//--- tsrc_timer_chk.sv
// port checker for the split reload capture timer
`timescale 1ns/100ps
module tsrc_timer_chk
  import tsrc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire tsrc_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rd_data_q,
  input wire logic count_tick,
  input wire logic comparator_zero_output,
  input wire logic timer_irq_enable,
  input wire logic capture_irq_ack,
  input wire logic timer_irq_req,
  input wire logic external_clock_select,
  input wire logic high_overflow_flag,
  input wire logic low_overflow_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire logic ctl_wr = sfr_req.wr_en && sfr_req.addr == 8'h91;
  // ==========
  // assertions
  a_irq_gated: assert property (!timer_irq_enable |-> !timer_irq_req)
    else $error("irq without enable");
  a_high_irq: assert property (timer_irq_enable && high_overflow_flag |-> timer_irq_req)
    else $error("high flag gives no irq");
  a_high_sticky: assert property (high_overflow_flag && !ctl_wr |=> high_overflow_flag)
    else $error("high flag cleared by hardware");
  a_rd_hold: assert property (!sfr_req.rd_en |=> $stable(sfr_rd_data_q))
    else $error("read data moved");
  a_ctl_bit0: assert property (ctl_wr |=> external_clock_select == $past(sfr_req.wr_data[0]))
    else $error("control write lost");
  a_low_cause: assert property ($rose(low_overflow_flag) && !$past(ctl_wr) |-> $past(count_tick))
    else $error("low flag without tick");
  a_high_cause: assert property ($rose(high_overflow_flag) && !$past(ctl_wr) |-> $past(count_tick))
    else $error("high flag without tick");
  a_capture_irq: assert property ($rose(timer_irq_req) && $stable(timer_irq_enable)
    && !high_overflow_flag && !low_overflow_flag
    |-> $past(comparator_zero_output) && !$past(comparator_zero_output, 2))
    else $error("irq without comparator edge");
  c_irq: cover property ($rose(timer_irq_req));
  c_high: cover property ($rose(high_overflow_flag));
  c_low: cover property ($rose(low_overflow_flag));
endmodule
bind tsrc_timer tsrc_timer_chk u_chk (.clk(clk), .rst(rst), .sfr_req(sfr_req),
  .sfr_rd_data_q(sfr_rd_data_q), .count_tick(count_tick),
  .comparator_zero_output(comparator_zero_output), .timer_irq_enable(timer_irq_enable),
  .capture_irq_ack(capture_irq_ack), .timer_irq_req(timer_irq_req),
  .external_clock_select(external_clock_select), .high_overflow_flag(high_overflow_flag),
  .low_overflow_flag(low_overflow_flag));

//--- tsrc_timer_bench.sv
// self-checking bench for the split reload capture timer
`timescale 1ns/100ps
module tsrc_timer_bench import tsrc_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  tsrc_sfr_req_t sfr_req = '0;
  logic count_tick = 1'b0;
  logic cmp = 1'b0;
  logic irq_en = 1'b0;
  logic ack = 1'b0;
  logic [7:0] rd_q;
  logic irq, xclk, hflag, lflag;
  int n_mismatch = 0;
  int n_tests = 0;
  tsrc_timer u_dut (.clk(clk), .rst(rst), .sfr_req(sfr_req), .sfr_rd_data_q(rd_q),
    .count_tick(count_tick), .comparator_zero_output(cmp), .timer_irq_enable(irq_en),
    .capture_irq_ack(ack), .timer_irq_req(irq), .external_clock_select(xclk),
    .high_overflow_flag(hflag), .low_overflow_flag(lflag));
  initial begin
    forever #5 clk = ~clk;
  end
  // ==========
  // tasks
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_req <= '{addr: a, wr_en: 1'b1, rd_en: 1'b0, wr_data: d};
    @(posedge clk);
    sfr_req.wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    sfr_req <= '{addr: a, wr_en: 1'b0, rd_en: 1'b1, wr_data: 8'h00};
    @(posedge clk);
    sfr_req.rd_en <= 1'b0;
    #1 chk("read data", exp, rd_q);
  endtask
  task automatic tick(input int n);
    @(posedge clk);
    count_tick <= 1'b1;
    repeat (n) @(posedge clk);
    count_tick <= 1'b0;
  endtask
  task automatic cmp_rise();
    @(posedge clk);
    cmp <= 1'b1;
    @(posedge clk);
    cmp <= 1'b0;
  endtask
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
  // ==========
  // sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(8'h91, 8'h00);
    rd(8'h92, 8'h00);
    rd(8'h90, 8'h00);
    wr(8'h92, 8'h5a);
    wr(8'h90, 8'h11);
    rd(8'h92, 8'h5a);
    wr(8'h91, 8'h03);
    rd(8'h91, 8'h01);
    chk("ext clock", 8'h01, {7'h00, xclk});
    wr(8'h93, 8'h12);
    wr(8'h92, 8'h34);
    wr(8'h94, 8'hfe);
    wr(8'h95, 8'hff);
    wr(8'h91, 8'h00);
    tick(1);
    rd(8'h94, 8'hfe);
    wr(8'h91, 8'h04);
    tick(2);
    rd(8'h94, 8'h34);
    rd(8'h95, 8'h12);
    rd(8'h91, 8'hc4);
    @(posedge clk);
    irq_en <= 1'b1;
    @(posedge clk);
    #1 chk("irq", 8'h01, {7'h00, irq});
    wr(8'h91, 8'h24);
    #1 chk("irq", 8'h00, {7'h00, irq});
    wr(8'h94, 8'hff);
    tick(1);
    #1 chk("irq", 8'h01, {7'h00, irq});
    chk("high flag", 8'h00, {7'h00, hflag});
    rd(8'h95, 8'h13);
    wr(8'h91, 8'h08);
    wr(8'h94, 8'hff);
    wr(8'h95, 8'hff);
    tick(1);
    #1 chk("low flag", 8'h01, {7'h00, lflag});
    chk("irq", 8'h00, {7'h00, irq});
    rd(8'h94, 8'h34);
    rd(8'h95, 8'hff);
    wr(8'h91, 8'h0c);
    tick(1);
    rd(8'h94, 8'h35);
    rd(8'h95, 8'h12);
    rd(8'h91, 8'h8c);
    chk("high flag", 8'h01, {7'h00, hflag});
    wr(8'h91, 8'h10);
    #1 chk("high flag", 8'h00, {7'h00, hflag});
    chk("low flag", 8'h00, {7'h00, lflag});
    wr(8'h95, 8'hab);
    wr(8'h94, 8'hcd);
    cmp_rise();
    rd(8'h92, 8'hcd);
    rd(8'h93, 8'hab);
    chk("irq", 8'h01, {7'h00, irq});
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    #1 chk("irq", 8'h00, {7'h00, irq});
    wr(8'h91, 8'h00);
    wr(8'h94, 8'h77);
    cmp_rise();
    rd(8'h92, 8'hcd);
    conclude();
  end
endmodule
